// ===== include/fault_pkg.sv
// Shared constants and carriers for the fault trip supervisor.
// Assumes a single 10 MHz system clock.
package fault_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int STOP_CHECK_S = 100;
  localparam int STOP_CHECK_CYCLES = STOP_CHECK_S * CLK_HZ;
  localparam int WDT_CYCLES = 10_000;
  localparam int RESTART_CYCLES = 1_000;
  localparam int POWERUP_CYCLES = 64;
  localparam int CNT_W = 32;

  // ----------------------------------------
  // Error codes and history
  // ----------------------------------------
  typedef logic [7:0] code_t;
  localparam code_t CODE_NONE = 8'h00;
  localparam code_t CODE_OC_CONST = 8'h01;
  localparam code_t CODE_OC_DECEL = 8'h02;
  localparam code_t CODE_OC_ACCEL = 8'h03;
  localparam code_t CODE_OC_OTHER = 8'h04;
  localparam code_t CODE_OVERLOAD = 8'h05;
  localparam code_t CODE_BUS_OVER = 8'h07;
  localparam code_t CODE_NVM = 8'h08;
  localparam code_t CODE_UNDER_V = 8'h09;
  localparam code_t CODE_CPU = 8'h0B;
  localparam code_t CODE_EXT_TRIP = 8'h0C;
  localparam code_t CODE_START_GUARD = 8'h0D;
  localparam code_t CODE_GND = 8'h0E;
  localparam code_t CODE_IN_OVER = 8'h0F;
  localparam code_t CODE_MODULE_HOT = 8'h15;
  localparam code_t CODE_DRIVER = 8'h1E;
  localparam code_t CODE_THERMISTOR = 8'h23;
  localparam code_t CODE_SAFETY = 8'h25;
  localparam code_t CODE_COMM = 8'h3C;
  localparam code_t INIT_CLEAR_HISTORY = 8'h00;
  localparam int HIST_DEPTH = 3;

  // ----------------------------------------
  // Enumerations and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    PHASE_CONST = 2'h0,
    PHASE_DECEL = 2'h1,
    PHASE_ACCEL = 2'h2,
    PHASE_OTHER = 2'h3
  } phase_e;

  typedef enum logic [4:0] {
    ST_POWERUP = 5'h01,
    ST_READY = 5'h02,
    ST_RUN = 5'h04,
    ST_RIDE = 5'h08,
    ST_TRIP = 5'h10
  } state_e;

  // Internal monitors, same clock domain
  typedef struct packed {
    logic over_current;
    logic thermal_overload;
    logic bus_over_v;
    logic nvm_fault;
    logic bus_under_v;
    logic cpu_fault;
    logic gnd_fault;
    logic input_over_v;
    logic module_hot;
    logic driver_fault;
    logic low_input_v;
    logic comm_beat;
    logic comm_enable;
  } fault_mon_s;

  // Terminal and keypad pins, asynchronous
  typedef struct packed {
    logic external_trip_function;
    logic safety_stop;
    logic thermistor_hot;
    logic run_cmd;
    logic stop_key;
    logic remote_clear_input;
  } pin_s;

  localparam int PIN_W = $bits(pin_s);

endpackage

// ===== logic/fault_trip_history_recorder.sv
// Fault trip supervisor: gathers faults, trips the power output, keeps history.
// Assumes monitors share clock_in; terminal and keypad pins are asynchronous.
`timescale 1ns/1ps
module fault_trip_history_recorder
  import fault_pkg::*;
#(
  parameter int STOP_CHECK = STOP_CHECK_CYCLES,
  parameter int WDT_LIMIT = WDT_CYCLES,
  parameter int RESTART_LIMIT = RESTART_CYCLES,
  parameter int POWERUP_LIMIT = POWERUP_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire fault_pkg::fault_mon_s monitor_in,
  input wire fault_pkg::phase_e phase_in,
  input wire fault_pkg::pin_s pins_in,
  input wire logic unattended_start_guard_in,
  input wire logic nv_mark_in,
  input wire logic init_write_in,
  input wire fault_pkg::code_t init_select_setting_in,
  output logic power_enable_out,
  output logic tripped_out,
  output fault_pkg::code_t display_code_out,
  output fault_pkg::code_t newest_fault_view_out,
  output fault_pkg::code_t middle_fault_view_out,
  output fault_pkg::code_t oldest_fault_view_out,
  output logic nv_mark_out
);
  import fault_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (STOP_CHECK < 1 || WDT_LIMIT < 1 || RESTART_LIMIT < 1 || POWERUP_LIMIT < 1)
    begin : g_bad
      $error("cycle counts must be at least one");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  pin_s pin;
  pin_sync #(.WIDTH(PIN_W)) u_sync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .pin_in(pins_in),
    .level_out(pin)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] wdt, next_wdt;
  logic key_prev, clr_prev;
  code_t code, next_code;
  logic power, next_power;
  logic tripped;
  logic log_pulse;
  code_t log_code;
  logic hist_clear;
  code_t hist [HIST_DEPTH];

  // Edge of the keypad stop key or the remote clear terminal
  logic clear_press;
  assign clear_press = (pin.stop_key && !key_prev)
    || (pin.remote_clear_input && !clr_prev);

  // ----------------------------------------
  // Fault selection, fixed priority
  // ----------------------------------------
  logic fault_hit;
  code_t fault_code;
  logic wdt_expired;
  assign wdt_expired = monitor_in.comm_enable && (wdt >= CNT_W'(WDT_LIMIT - 1));

  // Highest priority first: protection path, processor, memory, then the rest
  always_comb begin
    fault_hit = 1'b1;
    fault_code = CODE_NONE;
    if (monitor_in.driver_fault) begin
      fault_code = CODE_DRIVER;
    end else if (monitor_in.cpu_fault) begin
      fault_code = CODE_CPU;
    end else if (monitor_in.nvm_fault) begin
      fault_code = CODE_NVM;
    end else if (pin.safety_stop) begin
      fault_code = CODE_SAFETY;
    end else if (monitor_in.over_current) begin
      case (phase_in)
        PHASE_CONST: fault_code = CODE_OC_CONST;
        PHASE_DECEL: fault_code = CODE_OC_DECEL;
        PHASE_ACCEL: fault_code = CODE_OC_ACCEL;
        default: fault_code = CODE_OC_OTHER;
      endcase
    end else if (monitor_in.module_hot) begin
      fault_code = CODE_MODULE_HOT;
    end else if (pin.thermistor_hot) begin
      fault_code = CODE_THERMISTOR;
    end else if (monitor_in.bus_over_v) begin
      fault_code = CODE_BUS_OVER;
    end else if (monitor_in.bus_under_v) begin
      fault_code = CODE_UNDER_V;
    end else if (monitor_in.thermal_overload) begin
      fault_code = CODE_OVERLOAD;
    end else if (pin.external_trip_function) begin
      fault_code = CODE_EXT_TRIP;
    end else if (wdt_expired) begin
      fault_code = CODE_COMM;
    end else begin
      fault_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Network watchdog
  // ----------------------------------------
  // Restarts on every beat; idle while the network is disabled
  always_comb begin
    if (!monitor_in.comm_enable || monitor_in.comm_beat || state == ST_TRIP) begin
      next_wdt = '0;
    end else if (wdt_expired) begin
      next_wdt = wdt;
    end else begin
      next_wdt = wdt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdt <= '0;
    end else begin
      wdt <= next_wdt;
    end
  end

  // ----------------------------------------
  // Trip sequencer
  // ----------------------------------------
  // Faults are taken in every state, in a trip only on a clearing press; the first fault wins
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_code = code;
    next_power = 1'b0;
    log_pulse = 1'b0;
    log_code = CODE_NONE;
    case (state)
      ST_POWERUP: begin
        next_cnt = cnt + CNT_W'(1);
        if (fault_hit) begin
          log_code = fault_code;
        end else if (nv_mark_in) begin
          log_code = CODE_NVM;
        end else if (monitor_in.gnd_fault) begin
          log_code = CODE_GND;
        end else if (unattended_start_guard_in && pin.run_cmd) begin
          log_code = CODE_START_GUARD;
        end
        if (log_code != CODE_NONE) begin
          log_pulse = 1'b1;
        end else if (cnt >= CNT_W'(POWERUP_LIMIT - 1)) begin
          next_state = ST_READY;
          next_cnt = '0;
        end
      end
      ST_READY: begin
        next_cnt = cnt + CNT_W'(1);
        if (fault_hit) begin
          log_pulse = 1'b1;
          log_code = fault_code;
        end else if (cnt >= CNT_W'(STOP_CHECK - 1)) begin
          next_cnt = '0;
          if (monitor_in.input_over_v) begin
            log_pulse = 1'b1;
            log_code = CODE_IN_OVER;
          end
        end else if (pin.run_cmd) begin
          next_state = ST_RUN;
          next_power = 1'b1;
          next_cnt = '0;
        end
      end
      ST_RUN: begin
        next_power = 1'b1;
        if (fault_hit) begin
          log_pulse = 1'b1;
          log_code = fault_code;
        end else if (monitor_in.low_input_v) begin
          next_state = ST_RIDE;
          next_power = 1'b0;
          next_cnt = '0;
        end else if (!pin.run_cmd) begin
          next_state = ST_READY;
          next_power = 1'b0;
          next_cnt = '0;
        end
      end
      ST_RIDE: begin
        next_cnt = cnt + CNT_W'(1);
        if (fault_hit) begin
          log_pulse = 1'b1;
          log_code = fault_code;
        end else if (!monitor_in.low_input_v) begin
          next_state = pin.run_cmd ? ST_RUN : ST_READY;
          next_power = pin.run_cmd;
          next_cnt = '0;
        end else if (cnt >= CNT_W'(RESTART_LIMIT - 1)) begin
          log_pulse = 1'b1;
          log_code = CODE_UNDER_V;
        end
      end
      ST_TRIP: begin
        // A fault present on the clearing press trips again at once
        if (clear_press && fault_hit) begin
          log_pulse = 1'b1;
          log_code = fault_code;
        end else if (clear_press) begin
          next_state = ST_READY;
          next_code = CODE_NONE;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = ST_TRIP;
        next_code = CODE_CPU;
      end
    endcase
    if (log_pulse) begin
      next_state = ST_TRIP;
      next_power = 1'b0;
      next_code = log_code;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_POWERUP;
      cnt <= '0;
      code <= CODE_NONE;
      power <= 1'b0;
      tripped <= 1'b0;
      key_prev <= 1'b0;
      clr_prev <= 1'b0;
      nv_mark_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      code <= next_code;
      power <= next_power;
      tripped <= (next_state == ST_TRIP);
      key_prev <= pin.stop_key;
      clr_prev <= pin.remote_clear_input;
      nv_mark_out <= pin.remote_clear_input;
    end
  end

  // ----------------------------------------
  // History and outputs
  // ----------------------------------------
  assign hist_clear = init_write_in && (init_select_setting_in == INIT_CLEAR_HISTORY);

  trip_history #(.DEPTH(HIST_DEPTH)) u_hist (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .log_in(log_pulse),
    .code_in(log_code),
    .clear_in(hist_clear),
    .entry_out(hist)
  );

  assign power_enable_out = power;
  assign tripped_out = tripped;
  assign display_code_out = code;
  assign newest_fault_view_out = hist[0];
  assign middle_fault_view_out = hist[1];
  assign oldest_fault_view_out = hist[2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_trip_power_off: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    log_pulse |=> !power && state == ST_TRIP && newest_fault_view_out == code)
    else $error("trip did not drop power and log");
  a_trip_stopped: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state == ST_READY && fault_hit |=> state == ST_TRIP)
    else $error("fault ignored while stopped");
  a_clear_press: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state == ST_TRIP && clear_press && !fault_hit |=> state == ST_READY && code == CODE_NONE)
    else $error("stop key did not clear the trip");
  a_oc_phase: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state != ST_TRIP && monitor_in.over_current && !monitor_in.driver_fault
    && !monitor_in.cpu_fault && !monitor_in.nvm_fault && !pin.safety_stop
    && phase_in == PHASE_ACCEL |=> code == CODE_OC_ACCEL)
    else $error("over-current code does not match phase");
  a_guard_start: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state == ST_POWERUP && !fault_hit && !nv_mark_in && !monitor_in.gnd_fault
    && unattended_start_guard_in && pin.run_cmd |=> code == CODE_START_GUARD && !power)
    else $error("unattended start not refused");
  a_display_trip: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state == ST_TRIP |-> display_code_out != CODE_NONE && !power_enable_out)
    else $error("trip without a displayed code");
  a_ride_power: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state == ST_RUN && !fault_hit && monitor_in.low_input_v |=> state == ST_RIDE && !power)
    else $error("brownout did not cut output");
  a_wdt_trip: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state != ST_TRIP && fault_hit && fault_code == CODE_COMM |=> code == CODE_COMM)
    else $error("watchdog expiry not reported");

endmodule

// ===== logic/pin_sync.sv
// Three-stage synchroniser for asynchronous pins, one lane per bit.
// Assumes pins are slow levels; a change counts once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // ----------------------------------------
  // Per-bit lanes
  // ----------------------------------------
  genvar i;
  generate
    if (WIDTH < 1) begin : g_bad
      $error("pin_sync needs WIDTH of at least one");
    end
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1, s2, s3, lvl, next_lvl;
      // Accept a new level only when the last two stages agree
      always_comb begin
        next_lvl = (s2 == s3) ? s3 : lvl;
      end
      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_lvl;
        end
      end
      assign level_out[i] = lvl;

      a_sync_agree: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $changed(lvl) |-> $past(s2) == $past(s3))
        else $error("synchronised level moved without agreement");
    end
  endgenerate

endmodule

// ===== logic/trip_history.sv
// Three-entry trip history, newest first, held in flip-flops.
// Assumes log and clear strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module trip_history
  import fault_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic log_in,
  input wire fault_pkg::code_t code_in,
  input wire logic clear_in,
  output fault_pkg::code_t entry_out [DEPTH]
);
  import fault_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  code_t entry [DEPTH];
  code_t next_entry [DEPTH];

  generate
    if (DEPTH < 1) begin : g_bad
      $error("trip_history needs DEPTH of at least one");
    end
  endgenerate

  // Shift down on a log, newest in slot zero; a log beats a clear
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      if (log_in) begin
        next_entry[k] = (k == 0) ? code_in : entry[(k > 0) ? k - 1 : 0];
      end else if (clear_in) begin
        next_entry[k] = CODE_NONE;
      end else begin
        next_entry[k] = entry[k];
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int k = 0; k < DEPTH; k++) begin
        entry[k] <= CODE_NONE;
      end
    end else begin
      entry <= next_entry;
    end
  end

  assign entry_out = entry;

  a_hist_newest: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    log_in |=> entry[0] == $past(code_in))
    else $error("newest entry does not hold the logged code");
  a_hist_shift: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    log_in |=> entry[DEPTH-1] == $past(entry[DEPTH-2]))
    else $error("history did not shift down");
  a_hist_clear: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    clear_in && !log_in |=> entry[0] == CODE_NONE)
    else $error("history not erased by clear");
  a_hist_keep: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !log_in && !clear_in |=> $stable(entry[0]))
    else $error("history changed without log or clear");

endmodule

// ===== test/nv_store_model.sv
// Behavioural model of the nonvolatile marker store next to the supervisor.
// Assumes the supervisor reads the marker only during its power-up test.
`timescale 1ns/1ps
module nv_store_model #(
  parameter int SETTLE = 16
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic mark_in,
  output logic mark_out
);
  int unsigned up_count;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Holds over power loss; tracks the supervisor only once power-up is over
  initial begin
    mark_out = 1'b0;
    up_count = 0;
  end
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_count <= 0;
    end else if (up_count < SETTLE) begin
      up_count <= up_count + 1;
    end else begin
      mark_out <= mark_in;
    end
  end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the fault trip supervisor.
// Assumes shortened counts: stop check 200, watchdog 50, restart 20, power-up 8.
`timescale 1ns/1ps
module tb_top;
  import fault_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  fault_mon_s monitor_in = '0;
  phase_e phase_in = PHASE_CONST;
  pin_s pins_in = '0;
  logic unattended_start_guard_in = 1'b0;
  logic nv_mark_in;
  logic init_write_in = 1'b0;
  code_t init_select_setting_in = 8'h01;
  logic power_enable_out, tripped_out, nv_mark_out;
  code_t display_code_out, newest_fault_view_out, middle_fault_view_out;
  code_t oldest_fault_view_out;
  code_t hist [3] = '{default: CODE_NONE};
  int num_errors = 0;
  int tests_run = 0;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  // 10 MHz clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  fault_trip_history_recorder #(.STOP_CHECK(200), .WDT_LIMIT(50), .RESTART_LIMIT(20),
    .POWERUP_LIMIT(8)) DUT (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .monitor_in(monitor_in), .phase_in(phase_in), .pins_in(pins_in),
    .unattended_start_guard_in(unattended_start_guard_in), .nv_mark_in(nv_mark_in),
    .init_write_in(init_write_in), .init_select_setting_in(init_select_setting_in),
    .power_enable_out(power_enable_out), .tripped_out(tripped_out),
    .display_code_out(display_code_out), .newest_fault_view_out(newest_fault_view_out),
    .middle_fault_view_out(middle_fault_view_out),
    .oldest_fault_view_out(oldest_fault_view_out), .nv_mark_out(nv_mark_out));
  nv_store_model #(.SETTLE(16)) nv_store (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .mark_in(nv_mark_out), .mark_out(nv_mark_in));

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic check_code(input code_t got, input code_t exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Bounded wait for the trip flag to reach a level
  task automatic wait_trip(input logic want, input int limit);
    for (int i = 0; i < limit && tripped_out !== want; i++) @(negedge clock_in);
    check_bit(tripped_out, want);
  endtask
  task automatic check_views();
    check_code(newest_fault_view_out, hist[0]);
    check_code(middle_fault_view_out, hist[1]);
    check_code(oldest_fault_view_out, hist[2]);
  endtask
  // Waits for a trip, then checks output off, display and history shift
  task automatic expect_trip(input code_t code);
    wait_trip(1'b1, 400);
    @(negedge clock_in);
    check_bit(power_enable_out, 1'b0);
    check_code(display_code_out, code);
    hist[2] = hist[1];
    hist[1] = hist[0];
    hist[0] = code;
    check_views();
  endtask
  // Removes faults, sees the trip stand, then clears it with the key
  task automatic clear_trip(input code_t code);
    monitor_in = '0;
    pins_in = '0;
    repeat (6) @(negedge clock_in);
    check_bit(tripped_out, 1'b1);
    check_code(display_code_out, code);
    pins_in.stop_key = 1'b1;
    wait_trip(1'b0, 10);
    check_code(display_code_out, CODE_NONE);
    check_views();
    pins_in.stop_key = 1'b0;
    repeat (6) @(negedge clock_in);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic trip_case(input logic [12:0] mon, input logic [5:0] pn, input phase_e ph,
                           input logic run, input code_t code);
    @(negedge clock_in);
    phase_in = ph;
    pins_in.run_cmd = run;
    repeat (6) @(negedge clock_in);
    check_bit(power_enable_out, run);
    monitor_in = fault_mon_s'(mon);
    pins_in = pin_s'(pn | {3'h0, run, 2'h0});
    expect_trip(code);
    clear_trip(code);
  endtask
  task automatic history_clear();
    @(negedge clock_in);
    init_select_setting_in = 8'h01;
    init_write_in = 1'b1;
    @(negedge clock_in);
    init_write_in = 1'b0;
    @(negedge clock_in);
    check_views();
    init_select_setting_in = INIT_CLEAR_HISTORY;
    init_write_in = 1'b1;
    @(negedge clock_in);
    init_write_in = 1'b0;
    @(negedge clock_in);
    hist = '{default: CODE_NONE};
    check_views();
  endtask
  task automatic ride_through();
    @(negedge clock_in);
    pins_in.run_cmd = 1'b1;
    repeat (6) @(negedge clock_in);
    monitor_in.low_input_v = 1'b1;
    repeat (3) @(negedge clock_in);
    check_bit(power_enable_out, 1'b0);
    monitor_in.low_input_v = 1'b0;
    repeat (5) @(negedge clock_in);
    check_bit(power_enable_out, 1'b1);
    check_bit(tripped_out, 1'b0);
    pins_in.run_cmd = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask
  task automatic powerup_case(input logic guard, input logic [12:0] mon,
                              input logic remote, input code_t code);
    @(negedge clock_in);
    pins_in.remote_clear_input = remote;
    repeat (10) @(negedge clock_in);
    check_bit(nv_mark_out, remote);
    arst_n_in = 1'b0;
    pins_in = '0;
    pins_in.run_cmd = guard;
    unattended_start_guard_in = guard;
    monitor_in = fault_mon_s'(mon);
    hist = '{default: CODE_NONE};
    repeat (16) @(negedge clock_in);
    arst_n_in = 1'b1;
    expect_trip(code);
    clear_trip(code);
    unattended_start_guard_in = 1'b0;
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock_in);
    num_errors++;
    wrap_up();
  end
  initial begin
    static logic [12:0] mt [10] = '{13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080,
                             13'h0010, 13'h0008, 13'h0001, 13'h0020, 13'h0004};
    static code_t ct [10] = '{CODE_OVERLOAD, CODE_BUS_OVER, CODE_NVM, CODE_UNDER_V, CODE_CPU,
                       CODE_MODULE_HOT, CODE_DRIVER, CODE_COMM, CODE_IN_OVER, CODE_UNDER_V};
    static logic [5:0] pt [3] = '{6'h20, 6'h10, 6'h08};
    static code_t pc [3] = '{CODE_EXT_TRIP, CODE_SAFETY, CODE_THERMISTOR};
    repeat (16) @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (12) @(negedge clock_in);
    for (int p = 0; p < 4; p++) begin
      trip_case(13'h1000, 6'h00, phase_e'(p), p == 0, CODE_OC_CONST + code_t'(p));
    end
    for (int i = 0; i < 10; i++) begin
      trip_case(mt[i], 6'h00, PHASE_OTHER, i == 9, ct[i]);
    end
    for (int i = 0; i < 3; i++) begin
      trip_case(13'h0000, pt[i], PHASE_OTHER, 1'b0, pc[i]);
    end
    history_clear();
    ride_through();
    powerup_case(1'b1, 13'h0000, 1'b0, CODE_START_GUARD);
    powerup_case(1'b0, 13'h0040, 1'b0, CODE_GND);
    powerup_case(1'b0, 13'h0000, 1'b1, CODE_NVM);
    wrap_up();
  end
endmodule
